/* core/spp_pkg.sv */
// Package for the strobed parallel port block.
// Assumes one 20 MHz clock; one clock_output_pin cycle per clock enable pulse.
package spp_pkg;

    localparam int          SPP_DATA_W        = 8;
    localparam int          SPP_ADDR_W        = 16;
    localparam int          SPP_CNT_W         = 4;
    // Cycle counts in clock_output_pin periods
    localparam logic [3:0]  SPP_WR_DELAY      = 4'h2;
    localparam logic [3:0]  SPP_RD_DELAY      = 4'h3;
    localparam logic [3:0]  SPP_STB_LEN       = 4'h2;
    localparam logic [3:0]  SPP_LATCH_LEAD    = 4'h3;
    localparam logic [3:0]  SPP_STRETCH_BASE  = 4'h2;
    // Reset values
    localparam logic [7:0]  SPP_DATA_RST      = 8'h00;
    localparam logic [15:0] SPP_ADDR_RST      = 16'h0000;
    localparam logic [3:0]  SPP_CNT_RST       = 4'h0;

    typedef enum logic [3:0] {
        SPP_IDLE  = 4'b0001,
        SPP_WAIT  = 4'b0010,
        SPP_PULSE = 4'b0100,
        SPP_DONE  = 4'b1000
    } spp_state_type;

endpackage : spp_pkg

/* core/spp_port.sv */
// Strobed parallel port with external data-memory address steering.
// Assumes processor access requests are one-cycle pulses on sys_clk,
// and that the port pins are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module spp_port
    import spp_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  port_strobe_enable,
    input  wire logic                  port_wr_req,
    input  wire logic [SPP_DATA_W-1:0] port_wr_data,
    input  wire logic                  port_rd_req,
    output logic      [SPP_DATA_W-1:0] port_rd_data,
    output logic                       port_rd_valid,
    output logic                       port_busy,
    input  wire logic [SPP_DATA_W-1:0] port_pin_in,
    output logic      [SPP_DATA_W-1:0] port_pin_out,
    output logic      [SPP_DATA_W-1:0] port_pin_oe,
    input  wire logic [SPP_DATA_W-1:0] port_dir,
    input  wire logic                  xmem_req,
    input  wire logic                  xmem_wr,
    input  wire logic                  xmem_use_second,
    input  wire logic [SPP_ADDR_W-1:0] first_increment_pointer,
    input  wire logic [SPP_ADDR_W-1:0] second_increment_pointer,
    input  wire logic [2:0]            stretch,
    input  wire logic                  prog_fetch,
    output logic                       xmem_busy,
    output logic      [SPP_ADDR_W-1:0] xmem_addr,
    output logic                       clock_output_pin,
    output logic                       rd_strobe_n,
    output logic                       wr_strobe_n
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic                  clk_out;
        logic [SPP_DATA_W-1:0] pin_out;
        logic [SPP_DATA_W-1:0] rd_data;
        logic                  rd_valid;
        spp_state_type         mstate;
        logic [SPP_CNT_W-1:0]  mcnt;
        logic                  mwr;
        logic                  msecond;
        logic [SPP_ADDR_W-1:0] maddr;
        logic                  mrd_n;
        logic                  mwr_n;
        logic [SPP_ADDR_W-1:0] addr;
    } spp_top_type;

    spp_top_type cur_ff;
    spp_top_type nxt_cur;

    logic        cen;
    logic        wr_go;
    logic        rd_go;
    spp_stb_if   wr_if ();
    spp_stb_if   rd_if ();

    function automatic logic [SPP_CNT_W-1:0] spp_len(input logic [2:0] s);
        spp_len = SPP_STRETCH_BASE + {1'b0, s};
    endfunction : spp_len

    // One cen per clock_output_pin cycle (half-rate divider)
    assign cen = cur_ff.clk_out;

    ////////////////////////////////////////////////////////////////////////////
    // Port strobe sequencers

    assign wr_go = port_wr_req & port_strobe_enable & ~wr_if.busy;
    assign rd_go = port_rd_req & port_strobe_enable & ~rd_if.busy;

    assign wr_if.start = wr_go;
    assign wr_if.delay = SPP_WR_DELAY;
    assign rd_if.start = rd_go;
    assign rd_if.delay = SPP_RD_DELAY;

    spp_strobe_seq u_wr_seq (
        .sys_clk (sys_clk),
        .rst     (rst),
        .cen     (cen),
        .stb     (wr_if)
    );

    spp_strobe_seq u_rd_seq (
        .sys_clk (sys_clk),
        .rst     (rst),
        .cen     (cen),
        .stb     (rd_if)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt_cur          = cur_ff;
        nxt_cur.clk_out  = ~cur_ff.clk_out;
        nxt_cur.rd_valid = 1'b0;
        if (port_wr_req) begin
            nxt_cur.pin_out = port_wr_data;
        end
        // latch at read, three cycles ahead of strobe
        if (port_rd_req) begin
            nxt_cur.rd_data  = port_pin_in;
            nxt_cur.rd_valid = 1'b1;
        end
        // stretch applies to data memory only
        case (cur_ff.mstate)
            SPP_IDLE: begin
                nxt_cur.mrd_n = 1'b1;
                nxt_cur.mwr_n = 1'b1;
                if (xmem_req && !prog_fetch) begin
                    nxt_cur.mstate  = SPP_WAIT;
                    nxt_cur.mwr     = xmem_wr;
                    nxt_cur.msecond = xmem_use_second;
                    nxt_cur.maddr   = xmem_use_second ? second_increment_pointer
                                                      : first_increment_pointer;
                    nxt_cur.mcnt    = spp_len(stretch);
                end
            end
            SPP_WAIT: begin
                if (cen) begin
                    nxt_cur.mstate = SPP_PULSE;
                    nxt_cur.mrd_n  = cur_ff.mwr;
                    nxt_cur.mwr_n  = ~cur_ff.mwr;
                end
            end
            SPP_PULSE: begin
                if (cen) begin
                    if (cur_ff.mcnt <= 4'h1) begin
                        nxt_cur.mstate = SPP_DONE;
                        nxt_cur.mrd_n  = 1'b1;
                        nxt_cur.mwr_n  = 1'b1;
                    end else begin
                        nxt_cur.mcnt = cur_ff.mcnt - 4'h1;
                    end
                end
            end
            SPP_DONE: begin
                nxt_cur.mstate = SPP_IDLE;
            end
            default: begin
                nxt_cur.mstate = SPP_IDLE;
            end
        endcase
        if (nxt_cur.msecond) begin
            nxt_cur.addr = nxt_cur.maddr;
        end else if (!(nxt_cur.mrd_n && nxt_cur.mwr_n)) begin
            nxt_cur.addr = nxt_cur.maddr;
        end else begin
            nxt_cur.addr = SPP_ADDR_RST;
        end
        if (nxt_cur.mstate == SPP_IDLE) begin
            nxt_cur.addr = SPP_ADDR_RST;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur_ff <= '{clk_out: 1'b0, pin_out: SPP_DATA_RST, rd_data: SPP_DATA_RST,
                        rd_valid: 1'b0, mstate: SPP_IDLE, mcnt: SPP_CNT_RST,
                        mwr: 1'b0, msecond: 1'b0, maddr: SPP_ADDR_RST,
                        mrd_n: 1'b1, mwr_n: 1'b1, addr: SPP_ADDR_RST};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign clock_output_pin = cur_ff.clk_out;
    assign port_pin_out     = cur_ff.pin_out;
    assign port_pin_oe      = port_dir;
    assign port_rd_data     = cur_ff.rd_data;
    assign port_rd_valid    = cur_ff.rd_valid;
    assign port_busy        = wr_if.busy | rd_if.busy;
    assign xmem_busy        = (cur_ff.mstate != SPP_IDLE);
    assign xmem_addr        = cur_ff.addr;
    assign rd_strobe_n      = rd_if.strobe_n & cur_ff.mrd_n;
    assign wr_strobe_n      = wr_if.strobe_n & cur_ff.mwr_n;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_wr_low2;
        (!wr_if.strobe_n) [*4];
    endsequence

    AST_NO_STB_DISABLED: assert property (@(posedge sys_clk) disable iff (rst)
        (port_wr_req && !port_strobe_enable && !wr_if.busy) |=> !wr_if.busy)
        else $error("write strobe started while disabled");
    AST_WR_PULSE_LEN: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(wr_if.strobe_n) |-> s_wr_low2 ##1 wr_if.strobe_n)
        else $error("write strobe not two output cycles");
    AST_WR_DELAY: assert property (@(posedge sys_clk) disable iff (rst)
        wr_go |=> wr_if.strobe_n [*3] ##[1:2] !wr_if.strobe_n)
        else $error("write strobe delay wrong");
    AST_RD_DATA: assert property (@(posedge sys_clk) disable iff (rst)
        port_rd_req |=> port_rd_data == $past(port_pin_in))
        else $error("read data not latched at read");
    AST_RD_DELAY: assert property (@(posedge sys_clk) disable iff (rst)
        rd_go |=> rd_if.strobe_n [*5] ##[1:2] !rd_if.strobe_n)
        else $error("read strobe delay wrong");
    AST_RD_NO_SAMPLE: assert property (@(posedge sys_clk) disable iff (rst)
        ($fell(rd_if.strobe_n) && !$past(port_rd_req)) |-> $stable(port_rd_data))
        else $error("data sampled on read strobe");
    AST_FIRST_ADDR: assert property (@(posedge sys_clk) disable iff (rst)
        (!cur_ff.msecond && rd_strobe_n && wr_strobe_n) |-> xmem_addr == SPP_ADDR_RST)
        else $error("first pointer address outside strobe");
    AST_SECOND_ADDR: assert property (@(posedge sys_clk) disable iff (rst)
        (cur_ff.msecond && xmem_busy) |-> xmem_addr == cur_ff.maddr)
        else $error("second pointer address not held");
    AST_FETCH_NO_CYCLE: assert property (@(posedge sys_clk) disable iff (rst)
        (prog_fetch && !xmem_busy) |=> !xmem_busy)
        else $error("program fetch started a stretched cycle");
    AST_IDLE_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
        (!port_strobe_enable && !port_busy && !xmem_busy) |-> (rd_strobe_n && wr_strobe_n))
        else $error("strobe low while idle");

endmodule : spp_port
`default_nettype wire

/* core/spp_stb_if.sv */
// Interface carrying one strobe sequencer request and status.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface spp_stb_if;
    import spp_pkg::*;
    logic                 start;
    logic [SPP_CNT_W-1:0] delay;
    logic                 busy;
    logic                 strobe_n;

    modport master (output start, output delay, input busy, input strobe_n);
    modport slave  (input start, input delay, output busy, output strobe_n);
endinterface : spp_stb_if
`default_nettype wire

/* core/spp_strobe_seq.sv */
// Strobe sequencer: waits a delay, then drives an active-low pulse.
// Assumes cen is a one-cycle enable at the clock_output_pin rate.
`timescale 1ns/1ps
`default_nettype none
module spp_strobe_seq
    import spp_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic cen,
    spp_stb_if.slave  stb
);

    typedef struct packed {
        spp_state_type        state;
        logic [SPP_CNT_W-1:0] cnt;
        logic                 strobe_n;
    } spp_seq_type;

    spp_seq_type cur_ff;
    spp_seq_type nxt_cur;

    always_comb begin
        nxt_cur = cur_ff;
        case (cur_ff.state)
            SPP_IDLE: begin
                nxt_cur.strobe_n = 1'b1;
                if (stb.start) begin
                    nxt_cur.state = SPP_WAIT;
                    nxt_cur.cnt   = stb.delay;
                end
            end
            SPP_WAIT: begin
                if (cen) begin
                    if (cur_ff.cnt <= 4'h1) begin
                        nxt_cur.state    = SPP_PULSE;
                        nxt_cur.cnt      = SPP_STB_LEN;
                        nxt_cur.strobe_n = 1'b0;
                    end else begin
                        nxt_cur.cnt = cur_ff.cnt - 4'h1;
                    end
                end
            end
            SPP_PULSE: begin
                if (cen) begin
                    if (cur_ff.cnt <= 4'h1) begin
                        nxt_cur.state    = SPP_DONE;
                        nxt_cur.strobe_n = 1'b1;
                    end else begin
                        nxt_cur.cnt = cur_ff.cnt - 4'h1;
                    end
                end
            end
            SPP_DONE: begin
                nxt_cur.state = SPP_IDLE;
            end
            default: begin
                nxt_cur.state    = SPP_IDLE;
                nxt_cur.strobe_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur_ff <= '{state: SPP_IDLE, cnt: SPP_CNT_RST, strobe_n: 1'b1};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign stb.busy      = (cur_ff.state != SPP_IDLE);
    assign stb.strobe_n  = cur_ff.strobe_n;

    AST_SEQ_IDLE_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
        (cur_ff.state == SPP_IDLE) |-> cur_ff.strobe_n)
        else $error("strobe low while sequencer idle");

endmodule : spp_strobe_seq
`default_nettype wire

/* tb/spp_periph_model.sv */
// Peripheral logic on the far side of the strobed parallel port.
// Assumes rd_strobe_n is active low and synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module spp_periph_model
    import spp_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  rst,
    input  wire logic                  rd_strobe_n,
    input  wire logic                  slow,
    input  wire logic [SPP_DATA_W-1:0] next_byte,
    output logic      [SPP_DATA_W-1:0] pin_byte
);
    logic       prev_stb_ff;
    logic [2:0] lag_ff;
    always @(posedge sys_clk) begin
        prev_stb_ff <= rd_strobe_n;
        if (rst) begin
            pin_byte <= 8'h3c;
            lag_ff   <= 3'h0;
        end else if (prev_stb_ff === 1'b0 && rd_strobe_n === 1'b1) begin
            lag_ff <= slow ? 3'h4 : 3'h1;
        end else if (lag_ff == 3'h1) begin
            pin_byte <= next_byte;
            lag_ff   <= 3'h0;
        end else if (lag_ff != 3'h0) begin
            lag_ff <= lag_ff - 3'h1;
        end
    end
endmodule : spp_periph_model
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the strobed parallel port.
// Assumes the design and peripheral model share sys_clk at 20 MHz.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import spp_pkg::*;
    logic sys_clk = 1'b0, rst = 1'b1, port_strobe_enable, port_wr_req, port_rd_req;
    logic xmem_req, xmem_wr, xmem_use_second, prog_fetch, slow, port_busy, xmem_busy;
    logic port_rd_valid, rd_strobe_n, wr_strobe_n;
    logic co, co_prev = 1'b0, co_arm = 1'b0;
    logic [2:0]  stretch;
    logic [7:0]  port_wr_data, port_rd_data, port_pin_in, port_pin_out, port_pin_oe;
    logic [7:0]  port_dir, next_byte, pin_byte, seed;
    logic [15:0] first_increment_pointer, second_increment_pointer, xmem_addr, e;
    logic [7:0]  rd_q[$];
    logic [15:0] w_q[$];
    int          mismatches = 0, total_checks = 0, cycles = 0, low_n = 0;

    always #25 sys_clk = ~sys_clk;
    assign port_pin_in = (port_pin_out & port_pin_oe) | (pin_byte & ~port_pin_oe);

    spp_port spp_port_inst (.sys_clk(sys_clk), .rst(rst),
        .port_strobe_enable(port_strobe_enable), .port_wr_req(port_wr_req),
        .port_wr_data(port_wr_data), .port_rd_req(port_rd_req),
        .port_rd_data(port_rd_data), .port_rd_valid(port_rd_valid), .port_busy(port_busy),
        .port_pin_in(port_pin_in), .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe),
        .port_dir(port_dir), .xmem_req(xmem_req), .xmem_wr(xmem_wr),
        .xmem_use_second(xmem_use_second), .first_increment_pointer(first_increment_pointer),
        .second_increment_pointer(second_increment_pointer), .stretch(stretch),
        .prog_fetch(prog_fetch), .xmem_busy(xmem_busy), .xmem_addr(xmem_addr),
        .clock_output_pin(co), .rd_strobe_n(rd_strobe_n), .wr_strobe_n(wr_strobe_n));

    spp_periph_model spp_periph_model_inst (.sys_clk(sys_clk), .rst(rst),
        .rd_strobe_n(rd_strobe_n), .slow(slow), .next_byte(next_byte), .pin_byte(pin_byte));

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        total_checks++;
        if (lo === hi ? got !== lo : (got >= lo && got <= hi) !== 1'b1) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask : chk

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run

    task automatic wait_idle;
        int k;
        k = 0;
        while (k < 80 && (port_busy !== 1'b0 || xmem_busy !== 1'b0)) begin
            @(negedge sys_clk);
            k++;
        end
        chk(16'(k < 80), 16'h1, 16'h1);
    endtask : wait_idle

    task automatic port_op(input logic wr, input logic en);
        int n;
        n = 0;
        seed = lfsr(seed);
        @(posedge sys_clk);
        port_wr_data <= seed;
        next_byte    <= ~seed;
        port_dir     <= {8{wr}};
        if (wr) port_wr_req <= 1'b1;
        else port_rd_req <= 1'b1;
        // Two output cycles are four sys_clk cycles
        if (en) w_q.push_back(16'h4);
        @(negedge sys_clk);
        if (!wr) rd_q.push_back(port_pin_in);
        @(posedge sys_clk);
        port_wr_req <= 1'b0;
        port_rd_req <= 1'b0;
        while (en && n < 9 && (wr ? wr_strobe_n : rd_strobe_n) !== 1'b0) begin
            @(negedge sys_clk);
            n++;
        end
        if (en) chk(16'(n), wr ? 16'h3 : 16'h5, wr ? 16'h5 : 16'h7);
        else repeat (12) @(negedge sys_clk);
        if (!en) chk({14'h0, rd_strobe_n, wr_strobe_n}, 16'h3, 16'h3);
        wait_idle();
        if (wr) chk(16'(port_pin_out), 16'(seed), 16'(seed));
        chk(16'(port_pin_oe), {8'h0, {8{wr}}}, {8'h0, {8{wr}}});
    endtask : port_op

    task automatic xmem_op(input logic [2:0] st, input logic pf);
        seed = lfsr(seed);
        @(posedge sys_clk);
        first_increment_pointer  <= {seed, ~seed};
        second_increment_pointer <= {~seed, seed};
        xmem_use_second          <= st[0];
        xmem_wr                  <= st[1];
        stretch                  <= st;
        prog_fetch               <= pf;
        xmem_req                 <= 1'b1;
        if (!pf) w_q.push_back(16'(4 + 2 * st));
        @(posedge sys_clk);
        xmem_req <= 1'b0;
        repeat (2) @(negedge sys_clk);
        wait_idle();
    endtask : xmem_op

    ////////////////////////////////////////////////////////////////////////
    // Result monitor
    always @(negedge sys_clk) begin
        // Output clock toggles every sys_clk once out of reset
        if (co_arm) chk(16'(co ^ co_prev), 16'h1, 16'h1);
        co_arm  = (rst === 1'b0);
        co_prev = co;
        if (port_rd_valid === 1'b1) begin
            e = rd_q.size() != 0 ? 16'(rd_q.pop_front()) : 16'hxxxx;
            chk(16'(port_rd_data), e, e);
        end
        if (rd_strobe_n === 1'b0 || wr_strobe_n === 1'b0) begin
            low_n++;
            if (xmem_busy === 1'b1 && xmem_use_second === 1'b0)
                chk(xmem_addr, first_increment_pointer, first_increment_pointer);
        end else if (low_n != 0) begin
            e = w_q.size() != 0 ? w_q.pop_front() : 16'hxxxx;
            chk(16'(low_n), e, e);
            low_n = 0;
        end
        if (xmem_busy === 1'b1 && xmem_use_second === 1'b1)
            chk(xmem_addr, second_increment_pointer, second_increment_pointer);
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            mismatches++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {port_strobe_enable, port_wr_req, port_rd_req, xmem_req, xmem_wr} = 5'h0;
        {xmem_use_second, prog_fetch, slow, stretch} = 6'h0;
        {port_wr_data, port_dir, next_byte} = 24'h0;
        {first_increment_pointer, second_increment_pointer} = 32'h0;
        seed = 8'h19;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        @(negedge sys_clk);
        chk({14'h0, rd_strobe_n, wr_strobe_n}, 16'h3, 16'h3);
        for (int i = 0; i < 8; i++) begin
            @(posedge sys_clk);
            port_strobe_enable <= (i < 6);
            slow               <= i[1];
            port_op(i[0], i < 6);
        end
        for (int s = 0; s < 8; s++) xmem_op(3'(s), 1'b0);
        xmem_op(3'h3, 1'b1);
        repeat (20) @(negedge sys_clk);
        chk(16'(rd_q.size() + w_q.size()), 16'h0, 16'h0);
        complete_run();
    end
endmodule : tb
`default_nettype wire
